// ### pkg/wdgdc_pkg.sv
// package: watchdog down-counter constants, types and register map
package wdgdc_pkg;

    localparam int          WDGDC_PRESCALE      = 16384;
    localparam int          WDGDC_PRE_W         = 14;
    localparam int          WDGDC_CNT_W         = 7;
    localparam logic [6:0]  WDGDC_CNT_RESET     = 7'h7f;
    localparam int          WDGDC_CLK_PERIOD_NS = 10;
    localparam int          WDGDC_RST_PULSE_NS  = 500;
    localparam int          WDGDC_RST_PULSE_CYC =
        (WDGDC_RST_PULSE_NS + WDGDC_CLK_PERIOD_NS - 1) / WDGDC_CLK_PERIOD_NS;
    localparam int          WDGDC_PULSE_W       = 6;

    // register byte offsets
    localparam logic [11:0] WDGDC_CTRL_OFF      = 12'h000;
    localparam logic [11:0] WDGDC_OPT_OFF       = 12'h004;
    localparam logic [11:0] WDGDC_STAT_OFF      = 12'h008;

    // control register fields
    localparam int          WDGDC_ACT_BIT       = 7;
    localparam int          WDGDC_TOP_BIT       = 6;

    // option register fields
    localparam int          WDGDC_OPT_HALTRST   = 0;
    localparam int          WDGDC_OPT_HWWDG     = 1;
    localparam logic [1:0]  WDGDC_OPT_RESET     = 2'h0;

    typedef enum logic [1:0] {
        WDGDC_RUN      = 2'b00,
        WDGDC_HALT_DEC = 2'b01,
        WDGDC_HALTED   = 2'b10
    } wdgdc_halt_t;

    // reset cause seen by software
    typedef struct packed {
        logic sw_reset;
        logic timeout;
        logic halt_reset;
    } wdgdc_cause_t;

endpackage : wdgdc_pkg

// ### sim/wdgdc_monitor.sv
// checker: port-level watchdog properties
`timescale 1ns/10ps
module wdgdc_monitor
    import wdgdc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        wake_req,
    input wire logic        halted,
    input wire logic        reset_pin_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [6:0] low_q;
    logic       map;
    assign map = (paddr == WDGDC_CTRL_OFF) || (paddr == WDGDC_OPT_OFF)
        || (paddr == WDGDC_STAT_OFF);
    // pulse length counted here, too long for a repetition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_q <= 7'h00;
        else low_q <= reset_pin_n ? 7'h00 : low_q + 7'h01;
    end
    ////////////////////////////////////////////////////////////////
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence swr_s;
        pready && pwrite && paddr == WDGDC_CTRL_OFF && pwdata[7:6] == 2'b10;
    endsequence
    pready_next_a: assert property (setup_s |=> pready) else $error("no pready");
    pready_once_a: assert property (pready |=> !pready) else $error("long pready");
    slverr_map_a: assert property (pready |-> pslverr == !map) else $error("bad pslverr");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not 0");
    sw_reset_a: assert property (swr_s |-> ##[1:4] !reset_pin_n)
        else $error("no software reset");
    pulse_len_a: assert property ($rose(reset_pin_n) |-> low_q == WDGDC_RST_PULSE_CYC)
        else $error("bad pulse length");
    pulse_hold_a: assert property ($fell(reset_pin_n) |=> !reset_pin_n [*8])
        else $error("short pulse");
    halt_wake_a: assert property (halted && wake_req |-> ##[1:3] !halted)
        else $error("no wake");
endmodule : wdgdc_monitor

// ### sim/wdgdc_top_tb.sv
// testbench: apb-driven watchdog scenarios
`timescale 1ns/10ps
module wdgdc_top_tb;
    import wdgdc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        halt_req = 0, wake_req = 0, osc_irq_en = 0, err;
    logic        opt_halt_reset = 0, opt_hw_watchdog = 0;
    logic        pready, pslverr, halted, reset_pin_n;
    int          failures = 0, check_count = 0, t0, t1;
    wdgdc_top u_wdgdc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
        .wake_req(wake_req), .osc_irq_en(osc_irq_en), .halted(halted),
        .opt_halt_reset(opt_halt_reset), .opt_hw_watchdog(opt_hw_watchdog),
        .reset_pin_n(reset_pin_n));
    initial forever #5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////
    task conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task hang;
        failures++;
        conclude();
    endtask : hang
    task rst(input logic hr, input logic hw);
        opt_halt_reset <= hr;
        opt_hw_watchdog <= hw;
        presetn <= 0;
        repeat (8) @(posedge pclk);
        presetn <= 1;
    endtask : rst
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) hang();
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : xfer
    task rchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    // time of the next counter step, seen by polling reads
    task step(output int t);
        logic [31:0] v;
        int i;
        xfer(0, WDGDC_CTRL_OFF, 32'h0);
        v = rd;
        for (i = 0; i < 7000 && rd === v; i++) xfer(0, WDGDC_CTRL_OFF, 32'h0);
        if (rd === v) hang();
        chk(rd[6:0], 7'(v - 1));
        t = int'($time / 10);
    endtask : step
    task pin_pulse(input int n);
        int i;
        for (i = 0; i < n && reset_pin_n !== 1'b0; i++) @(posedge pclk);
        if (reset_pin_n !== 1'b0) hang();
        for (i = 0; i < 100 && reset_pin_n === 1'b0; i++) @(posedge pclk);
        chk(i, WDGDC_RST_PULSE_CYC);
    endtask : pin_pulse
    ////////////////////////////////////////////////////////////////
    initial begin
        rst(0, 0);
        rchk(WDGDC_CTRL_OFF, 32'h7f);
        rchk(WDGDC_STAT_OFF, 32'h0);
        xfer(1, 12'h00c, 32'hff);
        chk(err, 1'b1);
        xfer(0, 12'h00c, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        xfer(1, WDGDC_CTRL_OFF, 32'h55);
        rchk(WDGDC_CTRL_OFF, 32'h55);
        halt_req <= 1;
        @(posedge pclk);
        halt_req <= 0;
        repeat (3) @(posedge pclk);
        chk(halted, 1'b1);
        wake_req <= 1;
        @(posedge pclk);
        wake_req <= 0;
        repeat (3) @(posedge pclk);
        chk(halted, 1'b0);
        osc_irq_en <= 1;
        halt_req <= 1;
        @(posedge pclk);
        halt_req <= 0;
        repeat (3) @(posedge pclk);
        chk(halted, 1'b0);
        osc_irq_en <= 0;
        step(t0);
        xfer(1, WDGDC_CTRL_OFF, 32'hff);
        xfer(1, WDGDC_CTRL_OFF, 32'h45);
        rchk(WDGDC_CTRL_OFF, 32'hc5);
        step(t1);
        chk((t1 - t0 >= 16380) && (t1 - t0 <= 16388), 1'b1);
        // late reload: expiry must follow the old prescaler phase
        repeat (8000) @(posedge pclk);
        xfer(1, WDGDC_CTRL_OFF, 32'hc0);
        pin_pulse(9000);
        chk(($time / 10 - t1 >= 16376) && ($time / 10 - t1 <= 16442), 1'b1);
        rchk(WDGDC_STAT_OFF, 32'h2);
        rchk(WDGDC_CTRL_OFF, 32'h7f);
        xfer(1, WDGDC_STAT_OFF, 32'hf);
        xfer(1, WDGDC_CTRL_OFF, 32'h80);
        pin_pulse(10);
        rchk(WDGDC_STAT_OFF, 32'h4);
        rst(1, 0);
        xfer(1, WDGDC_CTRL_OFF, 32'hff);
        halt_req <= 1;
        @(posedge pclk);
        halt_req <= 0;
        pin_pulse(10);
        rchk(WDGDC_STAT_OFF, 32'h1);
        rst(0, 1);
        rchk(WDGDC_CTRL_OFF, 32'hff);
        xfer(1, WDGDC_CTRL_OFF, 32'h7f);
        rchk(WDGDC_CTRL_OFF, 32'hff);
        conclude();
    end
endmodule : wdgdc_top_tb
bind wdgdc_top wdgdc_monitor u_wdgdc_monitor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_req(wake_req),
    .halted(halted), .reset_pin_n(reset_pin_n));

// ### src/wdgdc_prescaler.sv
// file: free-running prescaler giving one tick per prescale period
`timescale 1ns/10ps
module wdgdc_prescaler #(
    parameter int PERIOD = wdgdc_pkg::WDGDC_PRESCALE,
    parameter int W      = wdgdc_pkg::WDGDC_PRE_W
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    output logic      tick
);
    import wdgdc_pkg::*;

    logic [W-1:0] count_q;

    // never cleared by software writes, so timeout has min/max spread
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (run) begin
            if (count_q == W'(PERIOD - 1)) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + W'(1);
            end
        end
    end

    assign tick = run && (count_q == W'(PERIOD - 1));

endmodule : wdgdc_prescaler

// ### src/wdgdc_pulse.sv
// file: fixed-length reset pulse generator
`timescale 1ns/10ps
module wdgdc_pulse #(
    parameter int CYCLES = wdgdc_pkg::WDGDC_RST_PULSE_CYC,
    parameter int W      = wdgdc_pkg::WDGDC_PULSE_W
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic fire,
    output logic      active
);
    import wdgdc_pkg::*;

    logic [W-1:0] left_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q <= '0;
        end else if (fire && left_q == '0) begin
            left_q <= W'(CYCLES);
        end else if (left_q != '0) begin
            left_q <= left_q - W'(1);
        end
    end

    assign active = (left_q != '0);

endmodule : wdgdc_pulse

// ### src/wdgdc_top.sv
// file: watchdog down-counter with apb register access
`timescale 1ns/10ps

// What this block does
// - counter decrements once per 16384 clock periods via the prescaler.
// - six low counter bits set timeout in 64 prescaler-period steps.
// - when active, counter passing 40h to 3Fh starts a reset.
// - watchdog reset drives reset pin low for about 500 ns.
// - counter runs down whether active or not; only reset depends on activation.
// - control writes leave the prescaler untouched.
// - after any reset the watchdog comes up inactive unless the hardware option is set.
// - once active, deactivation writes are ignored until reset.
// - write with activation set and top bit clear resets at once.
// - halt while active with the halt-reset option gives a reset instead of halting.
// - halt-reset choice comes from an option read at start-up.
// - hardware option makes watchdog active from reset.
// - halt without halt-reset or oscillator interrupt: one more decrement, then counting stops.
// - hardware mode keeps the activation bit set permanently.
module wdgdc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        halt_req,
    input  wire logic        wake_req,
    input  wire logic        osc_irq_en,
    input  wire logic        opt_halt_reset,
    input  wire logic        opt_hw_watchdog,
    output logic             halted,
    output logic             reset_pin_n
);
    import wdgdc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // timing overview
    //   tick     one cycle per prescale period; writes never restart it, so a
    //            reload lands anywhere inside the current step
    //   timeout  counter at 40h when the tick comes while active
    //   fire     timeout, software reset or halt reset, all in one cycle
    //   pulse    loads on the edge after fire; the pin follows one edge later
    //   pin low  for the pulse length; counter, activation and halt state are
    //            returned to their reset values meanwhile
    //   apb      setup edge prepares the answer, access edge applies writes
    //   halt     without halt reset or oscillator interrupt, one more step is taken, then all stops
    //            until a wake request

    ////////////////////////////////////////////////////////////////////
    // state

    logic [WDGDC_CNT_W-1:0] cnt_q;
    logic                   act_q;
    logic [1:0]             opt_q;
    logic                   opt_loaded_q;
    wdgdc_halt_t            hstate_q;
    wdgdc_cause_t           cause_q;
    logic                   tick;
    logic                   pulse_active;
    logic                   fire;
    logic                   run;
    logic                   ctrl_wr;
    logic                   acc;
    logic                   timeout_ev;
    logic                   swrst_ev;
    logic                   haltrst_ev;
    logic                   halt_ok;
    logic                   act_eff;
    logic                   act_d;
    logic                   setup;
    logic                   stat_wr;
    logic [WDGDC_CNT_W-1:0] cnt_d;
    logic [2:0]             cause_d;
    logic [2:0]             cause_set;

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction : addr_is

    ////////////////////////////////////////////////////////////////////
    // bus strobes

    // setup phase: the only cycle in which the response is prepared
    assign setup   = psel && !penable;
    // access phase: writes take effect here, once per transfer
    assign acc     = psel && penable;
    assign ctrl_wr = acc && pwrite && addr_is(paddr, WDGDC_CTRL_OFF);
    assign stat_wr = acc && pwrite && addr_is(paddr, WDGDC_STAT_OFF);
    // options are latched once after reset release, then held
    assign act_eff = act_q || (opt_loaded_q && opt_q[WDGDC_OPT_HWWDG]);

    ////////////////////////////////////////////////////////////////////
    // option capture at start-up
    // straps read once, so they cannot change under a running watchdog

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_q        <= WDGDC_OPT_RESET;
            opt_loaded_q <= 1'b0;
        end else if (!opt_loaded_q) begin
            opt_q[WDGDC_OPT_HALTRST] <= opt_halt_reset;
            opt_q[WDGDC_OPT_HWWDG]   <= opt_hw_watchdog;
            opt_loaded_q             <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // prescaler and pulse

    // stopped in halt so the counter freezes
    assign run = (hstate_q != WDGDC_HALTED);

    wdgdc_prescaler u_pre (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run),
        .tick    (tick)
    );

    assign timeout_ev = act_eff && tick && !ctrl_wr
                     && (cnt_q == 7'h40);
    assign swrst_ev   = ctrl_wr && pwdata[WDGDC_ACT_BIT]
                     && !pwdata[WDGDC_TOP_BIT];
    assign halt_ok    = halt_req && hstate_q == WDGDC_RUN && opt_loaded_q;
    assign haltrst_ev = halt_ok && act_eff && opt_q[WDGDC_OPT_HALTRST];
    assign fire       = timeout_ev || swrst_ev || haltrst_ev;

    // a fire while the pulse runs is absorbed: one pulse per event burst
    wdgdc_pulse u_pulse (
        .pclk    (pclk),
        .presetn (presetn),
        .fire    (fire),
        .active  (pulse_active)
    );

    ////////////////////////////////////////////////////////////////////
    // counter

    // priority: own reset pulse, then software load, then a prescaler step;
    // a load in the tick cycle wins, so that step is lost rather than doubled
    always_comb begin
        cnt_d = cnt_q;
        if (pulse_active) begin
            cnt_d = WDGDC_CNT_RESET;
        end else if (ctrl_wr) begin
            cnt_d = pwdata[WDGDC_CNT_W-1:0];
        end else if (tick) begin
            cnt_d = cnt_q - 7'h01;
        end
    end

    // keeps counting whether or not the watchdog is active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= WDGDC_CNT_RESET;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // activation: set-only; cleared by the watchdog's own reset pulse

    // writing zero has no effect, so software cannot switch it off
    always_comb begin
        act_d = act_q;
        if (pulse_active) begin
            act_d = 1'b0;
        end else if (ctrl_wr && pwdata[WDGDC_ACT_BIT]) begin
            act_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q <= 1'b0;
        end else begin
            act_q <= act_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // halt handling

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hstate_q <= WDGDC_RUN;
        end else if (pulse_active) begin
            hstate_q <= WDGDC_RUN;
        end else begin
            case (hstate_q)
                // with the oscillator interrupt on, the counter keeps running
                WDGDC_RUN: begin
                    if (halt_ok && !haltrst_ev && !osc_irq_en) begin
                        hstate_q <= WDGDC_HALT_DEC;
                    end
                end
                // prescaler still runs here: one more step, then it stops
                WDGDC_HALT_DEC: begin
                    if (wake_req) begin
                        hstate_q <= WDGDC_RUN;
                    end else if (tick) begin
                        hstate_q <= WDGDC_HALTED;
                    end
                end
                WDGDC_HALTED: begin
                    if (wake_req) begin
                        hstate_q <= WDGDC_RUN;
                    end
                end
                default: begin
                    hstate_q <= WDGDC_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // halt status

    // drops on the edge closing the wake cycle, with the halt state, so software sees it leave at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halted <= 1'b0;
        end else begin
            halted <= (hstate_q != WDGDC_RUN) && !wake_req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reset cause, sticky; cleared by writing ones, set wins
    // bit order follows the cause struct: software, timeout, halt

    assign cause_set = {swrst_ev, timeout_ev, haltrst_ev};

    // one flag per cause; an event in its own clearing cycle is kept
    always_comb begin
        cause_d = cause_q;
        for (int i = 0; i < 3; i++) begin
            if (stat_wr && pwdata[i]) begin
                cause_d[i] = 1'b0;
            end
            if (cause_set[i]) begin
                cause_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_q <= '0;
        end else begin
            cause_q <= wdgdc_cause_t'(cause_d);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reset pin

    // from a flop so the pin cannot glitch while the pulse counter loads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_pin_n <= 1'b1;
        end else begin
            reset_pin_n <= !pulse_active;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb decode

    // true for the three implemented words; all else answers with an error
    function automatic logic addr_mapped(input logic [11:0] a);
        return addr_is(a, WDGDC_CTRL_OFF)
            || addr_is(a, WDGDC_OPT_OFF)
            || addr_is(a, WDGDC_STAT_OFF);
    endfunction : addr_mapped

    // read word for an address, zero where nothing is implemented;
    // activation reads as the reset logic sees it, hardware mode included
    function automatic logic [31:0] read_word(
        input logic [11:0]            a,
        input logic                   act,
        input logic [WDGDC_CNT_W-1:0] cnt,
        input logic [2:0]             opt_word,
        input logic [3:0]             stat_word
    );
        logic [31:0] w;
        w = '0;
        if (addr_is(a, WDGDC_CTRL_OFF)) begin
            w = {24'h0, act, cnt};
        end else if (addr_is(a, WDGDC_OPT_OFF)) begin
            w = {29'h0, opt_word};
        end else if (addr_is(a, WDGDC_STAT_OFF)) begin
            w = {28'h0, stat_word};
        end
        return w;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////
    // apb response

    // no wait state: pready rises in the first access cycle and lasts one
    // cycle; the master must hold the request until it sees it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // error only beside pready, never left standing afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !addr_mapped(paddr);
        end
    end

    // read data stands only while pready is high and is zero otherwise,
    // so a stale word is never mistaken for a fresh answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup && !pwrite) begin
            prdata <= read_word(paddr, act_eff, cnt_q, {opt_loaded_q, opt_q},
                                {halted, cause_q});
        end else begin
            prdata <= '0;
        end
    end

endmodule : wdgdc_top
